// ===== logic/mwd_params.svh
// Purpose: Constants for the supervision watchdog and its serial register port
// Assumes: 125 MHz system clock, byte-wide registers
// Notes: Times are kept in their own unit, cycle counts derive from them
// Function
// - Strap low keeps watchdog permanently off
// - Strap capacitor starts watchdog, 31.875 s timeout
// - Strap high starts off, software enable only
// - Enable write then key BBh, else clear
// - No time limit; active only after key
// - Once enabled, cannot disable until reset
// - Service bit write then key AAh next
// - Expiry or wrong second write cancels service
// - Kick pin pulse of 100 ns services
// - Timeout is register value times 125 ms
// - Always time against current timeout value
// - Expiry sets history timeout flag
// - Masked enabled expiry sets status, interrupt low
// - Masked expiry pulses power good low 10 ms
// - Reset mask clear: expiry resets registers
// - Reset mask set: expiry reloads and restarts
// - Interrupts off at power on, global enable
// - Mask one enables; level sources interrupt immediately
// - Status read clears; levels return after 10 us
// - Bytes MSB first, framed by START and STOP
// - Acknowledge master bytes; master acknowledges read bytes
// - Address 0100 plus strapped low three bits
// - Read by pointer write, repeated START, read
`ifndef MWD_PARAMS_SVH
`define MWD_PARAMS_SVH

`define MWD_CLK_NS       8
`define MWD_UNIT_MS      125
`define MWD_UNIT_CYC     ((`MWD_UNIT_MS * 1000000) / `MWD_CLK_NS)
`define MWD_PG_MS        10
`define MWD_PG_CYC       ((`MWD_PG_MS * 1000000 + `MWD_CLK_NS - 1) / `MWD_CLK_NS)
`define MWD_KICK_NS      100
`define MWD_KICK_CYC     ((`MWD_KICK_NS + `MWD_CLK_NS - 1) / `MWD_CLK_NS)
`define MWD_OFF_US       10
`define MWD_OFF_CYC      ((`MWD_OFF_US * 1000 + `MWD_CLK_NS - 1) / `MWD_CLK_NS)

`define MWD_REG_ALARM    8'h00
`define MWD_REG_MASK     8'h01
`define MWD_REG_STAT     8'h02
`define MWD_REG_CTL      8'h04
`define MWD_REG_HIST     8'h05
`define MWD_REG_DEV      8'h06
`define MWD_REG_TOUT     8'h07

`define MWD_KEY_EN       8'hbb
`define MWD_KEY_SVC      8'haa

`define MWD_CTL_EN       4
`define MWD_CTL_INT      3
`define MWD_CTL_PG       2
`define MWD_CTL_RRM      1
`define MWD_CTL_SVC      0
`define MWD_DEV_RST      6
`define MWD_DEV_IEN      5

`define MWD_CTL_RST      8'h04
`define MWD_TOUT_RST     8'hff
`define MWD_CTL_WMASK    8'h1e
`define MWD_MASK_WMASK   8'h7e
`define MWD_HIST_WMASK   8'h1f
`define MWD_DEV_WMASK    8'h32
`define MWD_ALARM_RMASK  8'h7f

`define MWD_ADDR_HI      4'h4
`define MWD_STRAP_LOW    2'b00
`define MWD_STRAP_CAP    2'b01
`define MWD_STRAP_HIGH   2'b10
`define MWD_PIN_RST      8'h03

`endif

// ===== logic/mwd_pkg.sv
// Purpose: Types shared by the watchdog supervisor
// Assumes: Constants come from mwd_params.svh
// Notes: Access records carry one register read or write
package mwd_pkg;

  typedef enum logic [4:0]
  {
    MWD_IDLE = 5'b00001,
    MWD_RX   = 5'b00010,
    MWD_ACKD = 5'b00100,
    MWD_TX   = 5'b01000,
    MWD_ACKM = 5'b10000
  } mwd_i2c_st_t;

  typedef enum logic [1:0]
  {
    MWD_PH_ADDR = 2'b00,
    MWD_PH_REG  = 2'b01,
    MWD_PH_DATA = 2'b10
  } mwd_phase_t;

  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } mwd_access_t;

endpackage

// ===== logic/mwd_top.sv
// Purpose: Watchdog supervisor with strapped start mode and serial register port
// Assumes: Alarm status input comes from logic on clk_sys
// Notes: Pins pass two flip-flops before use; serial clock is sampled
`timescale 1ns/1ns
`default_nettype none
`include "mwd_params.svh"
module mwd_top
  import mwd_pkg::*;
#(
  parameter logic [23:0] UNIT_CYC = 24'(`MWD_UNIT_CYC),
  parameter logic [23:0] PG_CYC   = 24'(`MWD_PG_CYC)
)
(
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic [1:0] watchdog_startup_strap,
  input  wire logic [2:0] i2c_addr_strap,
  input  wire logic       watchdog_kick_pin,
  input  wire logic [7:0] alarm_status_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            interrupt_out_n,
  output logic            power_good_out
);

  logic [7:0]  pin_a_q;
  logic [7:0]  pin_b_q;
  logic        scl_p_q;
  logic        sda_p_q;
  logic [1:0]  start_cnt_q;
  logic        strap_done_q;
  logic [1:0]  strap_q;
  logic [2:0]  addr_q;
  logic        kick_ref_q;
  logic [3:0]  kick_cnt_q;
  mwd_i2c_st_t st_q;
  mwd_phase_t  phase_q;
  logic [3:0]  bit_q;
  logic [7:0]  sr_q;
  logic [7:0]  tx_q;
  logic [7:0]  ptr_q;
  logic        rw_q;
  logic        mack_q;
  mwd_access_t acc_q;
  logic [7:0]  ctl_q;
  logic [7:0]  mask_q;
  logic [7:0]  stat_q;
  logic [7:0]  hist_q;
  logic [7:0]  dev_q;
  logic [7:0]  tout_q;
  logic        wd_active_q;
  logic        en_pend_q;
  logic        svc_pend_q;
  logic [10:0] off_cnt_q;
  logic [23:0] pg_cnt_q;
  logic        expire;
  logic [7:0]  rd_data;

  wire [7:0] pin_raw = {watchdog_startup_strap, i2c_addr_strap, watchdog_kick_pin,
                        scl_in, sda_in};

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_a_q <= `MWD_PIN_RST;
      pin_b_q <= `MWD_PIN_RST;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      pin_a_q <= pin_raw;
      pin_b_q <= pin_a_q;
      scl_p_q <= pin_b_q[1];
      sda_p_q <= pin_b_q[0];
    end
  end

  wire       sda_s   = pin_b_q[0];
  wire       scl_s   = pin_b_q[1];
  wire       kick_s  = pin_b_q[2];
  wire [2:0] addr_s  = pin_b_q[5:3];
  wire [1:0] strap_s = pin_b_q[7:6];

  // Straps are caught once, after the synchronisers have filled
  wire strap_take = !strap_done_q && (start_cnt_q == 2'h3);
  wire strap_low  = (strap_q == `MWD_STRAP_LOW);
  wire strap_cap  = (strap_q == `MWD_STRAP_CAP);

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      start_cnt_q  <= 2'h0;
      strap_done_q <= 1'b0;
      strap_q      <= `MWD_STRAP_HIGH;
      addr_q       <= 3'h0;
    end
    else if (strap_take)
    begin
      strap_done_q <= 1'b1;
      strap_q      <= strap_s;
      addr_q       <= addr_s;
    end
    else if (!strap_done_q)
      start_cnt_q <= start_cnt_q + 2'h1;
  end

  // Kick pin: new level must hold for the minimum pulse time
  wire kick_diff = (kick_s != kick_ref_q);
  wire kick_ok   = kick_diff && (kick_cnt_q == 4'(`MWD_KICK_CYC - 1));

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      kick_ref_q <= 1'b0;
      kick_cnt_q <= 4'h0;
    end
    else
    begin
      kick_ref_q <= kick_ok ? kick_s : kick_ref_q;
      kick_cnt_q <= (kick_diff && !kick_ok) ? kick_cnt_q + 4'h1 : 4'h0;
    end
  end

  wire scl_rise   = scl_s && !scl_p_q;
  wire scl_fall   = !scl_s && scl_p_q;
  wire i2c_start  = scl_s && scl_p_q && !sda_s && sda_p_q;
  wire i2c_stop   = scl_s && scl_p_q && sda_s && !sda_p_q;
  wire addr_match = (sr_q[7:1] == {`MWD_ADDR_HI, addr_q});
  wire rx_done    = (st_q == MWD_RX) && scl_fall && (bit_q == 4'h8);
  wire tx_load    = scl_fall && (((st_q == MWD_ACKD) && rw_q && (phase_q == MWD_PH_ADDR))
                    || ((st_q == MWD_ACKM) && mack_q));
  wire [1:0] ph_next = (phase_q == MWD_PH_ADDR) ? MWD_PH_REG : MWD_PH_DATA;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q    <= MWD_IDLE;
      phase_q <= MWD_PH_ADDR;
      bit_q   <= 4'h0;
      sr_q    <= 8'h00;
      tx_q    <= 8'h00;
      ptr_q   <= 8'h00;
      rw_q    <= 1'b0;
      mack_q  <= 1'b0;
      sda_oe  <= 1'b0;
    end
    else if (i2c_stop || !strap_done_q)
    begin
      st_q   <= MWD_IDLE;
      sda_oe <= 1'b0;
    end
    else if (i2c_start)
    begin
      st_q    <= MWD_RX;
      phase_q <= MWD_PH_ADDR;
      bit_q   <= 4'h0;
      sda_oe  <= 1'b0;
    end
    else
    begin
      unique case (st_q)
        MWD_IDLE:
          sda_oe <= 1'b0;
        MWD_RX:
          if (scl_rise)
          begin
            sr_q  <= {sr_q[6:0], sda_s};
            bit_q <= bit_q + 4'h1;
          end
          else if (rx_done)
          begin
            st_q   <= (phase_q != MWD_PH_ADDR || addr_match) ? MWD_ACKD : MWD_IDLE;
            sda_oe <= (phase_q != MWD_PH_ADDR || addr_match);
            if (phase_q == MWD_PH_ADDR)
              rw_q <= sr_q[0];
            if (phase_q == MWD_PH_REG)
              ptr_q <= sr_q;
          end
        MWD_ACKD:
          if (scl_fall)
          begin
            bit_q <= 4'h0;
            if (tx_load)
            begin
              st_q   <= MWD_TX;
              tx_q   <= rd_data;
              sda_oe <= !rd_data[7];
            end
            else
            begin
              st_q    <= MWD_RX;
              phase_q <= mwd_phase_t'(ph_next);
              sda_oe  <= 1'b0;
            end
          end
        MWD_TX:
          if (scl_rise)
            bit_q <= bit_q + 4'h1;
          else if (scl_fall && (bit_q == 4'h8))
          begin
            st_q   <= MWD_ACKM;
            sda_oe <= 1'b0;
          end
          else if (scl_fall)
          begin
            tx_q   <= {tx_q[6:0], 1'b0};
            sda_oe <= !tx_q[6];
          end
        MWD_ACKM:
          if (scl_rise)
            mack_q <= !sda_s;
          else if (tx_load)
          begin
            st_q   <= MWD_TX;
            bit_q  <= 4'h0;
            tx_q   <= rd_data;
            sda_oe <= !rd_data[7];
          end
          else if (scl_fall)
            st_q <= MWD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc_q   <= '0;
      sda_out <= 1'b0;
    end
    else
    begin
      acc_q.wr   <= rx_done && (phase_q == MWD_PH_DATA);
      acc_q.rd   <= tx_load;
      acc_q.addr <= ptr_q;
      acc_q.data <= sr_q;
      sda_out    <= 1'b0;
    end
  end

  assign rd_data =
    (ptr_q == `MWD_REG_ALARM) ? (alarm_status_in & `MWD_ALARM_RMASK) :
    (ptr_q == `MWD_REG_MASK)  ? mask_q :
    (ptr_q == `MWD_REG_STAT)  ? stat_q :
    (ptr_q == `MWD_REG_CTL)   ? {ctl_q[7:5], ctl_q[4] | wd_active_q, ctl_q[3:1], svc_pend_q} :
    (ptr_q == `MWD_REG_HIST)  ? hist_q :
    (ptr_q == `MWD_REG_DEV)   ? dev_q :
    (ptr_q == `MWD_REG_TOUT)  ? tout_q :
    8'h00;

  wire any_acc  = acc_q.wr || acc_q.rd;
  wire wr_key   = acc_q.wr && (acc_q.addr == `MWD_REG_ALARM);
  wire key_en   = wr_key && (acc_q.data == `MWD_KEY_EN);
  wire key_svc  = wr_key && (acc_q.data == `MWD_KEY_SVC);
  wire wr_ctl   = acc_q.wr && (acc_q.addr == `MWD_REG_CTL);
  wire wr_dev   = acc_q.wr && (acc_q.addr == `MWD_REG_DEV);
  wire rd_stat  = acc_q.rd && (acc_q.addr == `MWD_REG_STAT);
  wire en_start = wr_ctl && acc_q.data[`MWD_CTL_EN] && !wd_active_q && !strap_low;
  wire svc_ok   = svc_pend_q && key_svc && !expire;
  wire regs_rst = (expire && !ctl_q[`MWD_CTL_RRM]) || (wr_dev && acc_q.data[`MWD_DEV_RST]);
  wire ien      = dev_q[`MWD_DEV_IEN];
  wire off_done = (off_cnt_q == 11'h000);
  wire [5:0] lvl_set = alarm_status_in[6:1] & mask_q[6:1]
                       & {6{ien && off_done && !rd_stat}};
  wire wd_set   = expire && ctl_q[`MWD_CTL_INT] && ien;

  // Timer keeps running through a register reset if the strap started it
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wd_active_q <= 1'b0;
      en_pend_q   <= 1'b0;
      svc_pend_q  <= 1'b0;
      ctl_q       <= `MWD_CTL_RST;
    end
    else if (strap_take)
      wd_active_q <= (strap_s == `MWD_STRAP_CAP);
    else if (regs_rst)
    begin
      wd_active_q <= strap_cap;
      en_pend_q   <= 1'b0;
      svc_pend_q  <= 1'b0;
      ctl_q       <= `MWD_CTL_RST;
    end
    else
    begin
      if (en_start)
      begin
        ctl_q     <= acc_q.data & `MWD_CTL_WMASK;
        en_pend_q <= 1'b1;
      end
      else if (en_pend_q && any_acc)
      begin
        en_pend_q   <= 1'b0;
        wd_active_q <= key_en;
        ctl_q[`MWD_CTL_EN] <= key_en;
      end
      if (wd_active_q && wr_ctl && acc_q.data[`MWD_CTL_SVC])
        svc_pend_q <= 1'b1;
      else if (svc_pend_q && (any_acc || expire))
        svc_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mask_q <= 8'h00;
      dev_q  <= 8'h00;
      tout_q <= `MWD_TOUT_RST;
    end
    else if (regs_rst)
    begin
      mask_q <= 8'h00;
      dev_q  <= 8'h00;
      tout_q <= `MWD_TOUT_RST;
    end
    else if (acc_q.wr)
    begin
      if (acc_q.addr == `MWD_REG_MASK)
        mask_q <= acc_q.data & `MWD_MASK_WMASK;
      if (acc_q.addr == `MWD_REG_DEV)
        dev_q <= acc_q.data & `MWD_DEV_WMASK;
      if (acc_q.addr == `MWD_REG_TOUT)
        tout_q <= acc_q.data;
    end
  end

  // Status and history survive a register reset; expiry sets win over clears
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stat_q    <= 8'h00;
      hist_q    <= 8'h00;
      off_cnt_q <= 11'h000;
      pg_cnt_q  <= 24'h000000;
    end
    else
    begin
      stat_q <= (rd_stat ? 8'h00 : stat_q) | {1'b0, lvl_set, wd_set};
      hist_q <= ((acc_q.wr && acc_q.addr == `MWD_REG_HIST) ? (acc_q.data & `MWD_HIST_WMASK)
                 : hist_q) | {7'h00, expire};
      off_cnt_q <= rd_stat ? 11'(`MWD_OFF_CYC - 1) : (off_done ? 11'h000 : off_cnt_q - 11'h001);
      if (expire && ctl_q[`MWD_CTL_PG])
        pg_cnt_q <= PG_CYC;
      else if (pg_cnt_q != 24'h000000)
        pg_cnt_q <= pg_cnt_q - 24'h000001;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      interrupt_out_n <= 1'b1;
      power_good_out  <= 1'b0;
    end
    else
    begin
      interrupt_out_n <= !(|stat_q);
      power_good_out  <= !((pg_cnt_q != 24'h000000) || alarm_status_in[0]);
    end
  end

  mwd_wd_timer #(
    .UNIT_CYC (UNIT_CYC)
  ) u_timer (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .run      (wd_active_q),
    .restart  (svc_ok || kick_ok),
    .period   (tout_q),
    .expire   (expire)
  );

  strap_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    strap_done_q && strap_low |-> !wd_active_q)
    else $error("watchdog active with low strap");

  strap_start_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(strap_done_q) |-> (wd_active_q == strap_cap) && (tout_q == `MWD_TOUT_RST))
    else $error("startup mode does not follow strap");

  enable_key_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    en_pend_q && key_en && !expire && !strap_take |=> wd_active_q)
    else $error("keyed enable not accepted");

  enable_cancel_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    en_pend_q && any_acc && !key_en && !en_start && !wd_active_q && !regs_rst
    |=> !ctl_q[`MWD_CTL_EN] && !wd_active_q)
    else $error("enable bit kept after wrong access");

  sticky_enable_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wd_active_q && !regs_rst |=> wd_active_q)
    else $error("watchdog disabled without register reset");

  svc_cancel_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    svc_pend_q && expire && !(wd_active_q && wr_ctl) |=> !svc_pend_q)
    else $error("service request survived expiry");

  history_set_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    expire |=> hist_q[0])
    else $error("history flag not set on expiry");

  irq_pin_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wd_set |-> ##1 stat_q[0] ##1 !interrupt_out_n)
    else $error("watchdog interrupt not raised");

  pg_pulse_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    expire && ctl_q[`MWD_CTL_PG] |-> ##2 !power_good_out [*8])
    else $error("power good pulse missing");

  reg_reset_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    expire && !ctl_q[`MWD_CTL_RRM] |=> (tout_q == `MWD_TOUT_RST) && (mask_q == 8'h00))
    else $error("registers not reset on expiry");

  off_time_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rd_stat && !expire |=> (stat_q[6:1] == 6'h00) [*8])
    else $error("level interrupt back inside off time");

endmodule
`default_nettype wire

// ===== logic/mwd_top_end.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ===== logic/mwd_wd_timer.sv
// Purpose: Watchdog timeout counter in 125 ms units
// Assumes: Period of zero is never programmed
// Notes: Reloads itself on every expiry
`timescale 1ns/1ns
`default_nettype none
`include "mwd_params.svh"
module mwd_wd_timer
#(
  parameter logic [23:0] UNIT_CYC = 24'(`MWD_UNIT_CYC)
)
(
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic [7:0] period,
  output logic            expire
);

  logic [23:0] pre_q;
  logic [7:0]  units_q;

  wire unit_tick = (pre_q == UNIT_CYC - 24'h000001);
  // Compared each tick, so a new period takes effect at once
  wire hit = unit_tick && (({1'b0, units_q} + 9'h001) >= {1'b0, period});

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pre_q   <= 24'h000000;
      units_q <= 8'h00;
      expire  <= 1'b0;
    end
    else
    begin
      expire <= run && hit && !restart;
      if (!run || restart || hit)
      begin
        pre_q   <= 24'h000000;
        units_q <= 8'h00;
      end
      else if (unit_tick)
      begin
        pre_q   <= 24'h000000;
        units_q <= units_q + 8'h01;
      end
      else
        pre_q <= pre_q + 24'h000001;
    end
  end

  unit_count_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    expire |-> $past(units_q) + 8'h01 >= $past(period))
    else $error("expiry before programmed period");

endmodule
`default_nettype wire

// ===== testbench/mwd_host_model.sv
// Purpose: Bus master model that reaches the supervisor registers
// Assumes: Open-drain data line with pull-up, resolved by the bench
// Notes: Serial clock stands high between frames, 125 ns bit time
`timescale 1ns/1ns
`default_nettype none
module mwd_host_model
(
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic bit_cyc(input logic b, output logic r);
    #31 sda_low = ~b;
    #31 scl = 1'b1;
    #31 r = sda;
    #32 scl = 1'b0;
  endtask

  // Serves for both START and repeated START
  task automatic start();
    #31 sda_low = 1'b0;
    #31 scl = 1'b1;
    #31 sda_low = 1'b1;
    #31 scl = 1'b0;
  endtask

  task automatic stop();
    #31 sda_low = 1'b1;
    #31 scl = 1'b1;
    #31 sda_low = 1'b0;
    #31;
  endtask

  task automatic send(input logic [7:0] d, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_cyc(d[i], r);
    bit_cyc(1'b1, r);
    ok &= ~r;
  endtask

  task automatic reg_write(input logic [6:0] dev, input logic [7:0] ra,
                           input logic [7:0] d, output logic ok);
    ok = 1'b1;
    start();
    send({dev, 1'b0}, ok);
    send(ra, ok);
    send(d, ok);
    stop();
  endtask

  // Single byte read, closed by a refusal of further data
  task automatic reg_read(input logic [6:0] dev, input logic [7:0] ra,
                          output logic [7:0] d, output logic ok);
    logic r;
    ok = 1'b1;
    start();
    send({dev, 1'b0}, ok);
    send(ra, ok);
    start();
    send({dev, 1'b1}, ok);
    for (int i = 7; i >= 0; i--)
      bit_cyc(1'b1, d[i]);
    bit_cyc(1'b1, r);
    stop();
  endtask
endmodule
`default_nettype wire

// ===== testbench/test_mgmt_watchdog_irq_i2c.sv
// Purpose: Self-checking bench for the watchdog supervisor
// Assumes: Shortened unit and pulse counts, master model on the link
// Notes: Straps change only while reset is held
`timescale 1ns/1ns
`default_nettype none
`include "mwd_params.svh"
module test_mgmt_watchdog_irq_i2c;
  localparam int UNIT = 200;
  localparam int PGW  = 20;
  logic        clk_sys     = 1'b0;
  logic        reset_n     = 1'b0;
  logic [1:0]  strap       = 2'b10;
  logic [2:0]  adr         = 3'h0;
  logic        kick        = 1'b0;
  logic [7:0]  alarm       = 8'h00;
  logic [31:0] rng         = 32'h0000a9ed;
  logic        scl;
  logic        sda_low;
  logic        sda_oe;
  logic        sda_out;
  logic        int_n;
  logic        pg;
  wire logic   sda         = ~(sda_low | (sda_oe & ~sda_out));
  int          n_fail      = 0;
  int          checks_done = 0;
  int          pg_falls    = 0;
  int          gap         = 0;
  int          width       = 0;
  time         last_fall   = 0;

  always #4 clk_sys = ~clk_sys;

  always @(negedge pg)
    if (reset_n)
    begin
      pg_falls++;
      gap       = int'(($time - last_fall) / 8);
      last_fall = $time;
    end

  always @(posedge pg)
    width = int'(($time - last_fall) / 8);

  mwd_top #(.UNIT_CYC(24'h0000c8), .PG_CYC(24'h000014)) mwd_top_inst
  (
    .clk_sys               (clk_sys),
    .reset_n               (reset_n),
    .watchdog_startup_strap(strap),
    .i2c_addr_strap        (adr),
    .watchdog_kick_pin     (kick),
    .alarm_status_in       (alarm),
    .scl_in                (scl),
    .sda_in                (sda),
    .sda_out               (sda_out),
    .sda_oe                (sda_oe),
    .interrupt_out_n       (int_n),
    .power_good_out        (pg)
  );

  mwd_host_model mwd_host_model_inst
  (
    .scl    (scl),
    .sda_low(sda_low),
    .sda    (sda)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic [7:0] exp_stat(input logic [7:0] a, input logic [7:0] m);
    return a & m & 8'h7e;
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    logic ok;
    mwd_host_model_inst.reg_write({`MWD_ADDR_HI, adr}, ra, d, ok);
    check({7'h00, ok}, 8'h01);
  endtask

  task automatic rd(input logic [7:0] ra, input logic [7:0] exp);
    logic       ok;
    logic [7:0] d;
    mwd_host_model_inst.reg_read({`MWD_ADDR_HI, adr}, ra, d, ok);
    check({7'h00, ok}, 8'h01);
    check(d, exp);
  endtask

  task automatic do_reset(input logic [1:0] s);
    @(negedge clk_sys);
    reset_n = 1'b0;
    strap   = s;
    rng     = xs(rng);
    adr     = rng[2:0];
    idle(6);
    reset_n = 1'b1;
    idle(20);
  endtask

  // Bounded wait for the next watchdog pulse on the power-good pin
  task automatic wait_pg(input int lim);
    int n = pg_falls;
    int c = 0;
    while (pg_falls == n)
    begin
      idle(1);
      c++;
      if (c > lim)
      begin
        check(8'h00, 8'h01);
        close_out();
      end
    end
  endtask

  initial
  begin
    logic [7:0] m;
    logic [7:0] e;
    logic       ok;
    int         f;
    do_reset(2'b10);
    rng   = xs(rng);
    alarm = rng[7:0] & 8'hfe;
    rd(`MWD_REG_ALARM, alarm & `MWD_ALARM_RMASK);
    rd(`MWD_REG_MASK, 8'h00);
    rd(`MWD_REG_STAT, 8'h00);
    rd(`MWD_REG_CTL, `MWD_CTL_RST);
    rd(`MWD_REG_HIST, 8'h00);
    rd(`MWD_REG_DEV, 8'h00);
    mwd_host_model_inst.reg_write({`MWD_ADDR_HI, ~adr}, `MWD_REG_TOUT, 8'h01, ok);
    check({7'h00, ok}, 8'h00);
    rd(`MWD_REG_TOUT, `MWD_TOUT_RST);
    wr(`MWD_REG_TOUT, 8'h01);
    wr(`MWD_REG_CTL, 8'h1e);
    rd(`MWD_REG_HIST, 8'h00);
    wr(`MWD_REG_ALARM, `MWD_KEY_EN);
    rd(`MWD_REG_ALARM, alarm & `MWD_ALARM_RMASK);
    f = pg_falls;
    idle(600);
    check(8'(pg_falls - f), 8'h00);
    rd(`MWD_REG_CTL, 8'h0e);
    wr(`MWD_REG_DEV, 8'h20);
    wr(`MWD_REG_TOUT, 8'h02);
    wr(`MWD_REG_CTL, 8'h1e);
    wr(`MWD_REG_ALARM, `MWD_KEY_EN);
    wait_pg(1000);
    wait_pg(1000);
    check({7'h00, gap >= 2 * UNIT - 2 && gap <= 2 * UNIT + 2}, 8'h01);
    check({7'h00, width >= PGW}, 8'h01);
    check({7'h00, int_n}, 8'h00);
    rd(`MWD_REG_HIST, 8'h01);
    rd(`MWD_REG_STAT, 8'h01);
    wr(`MWD_REG_CTL, 8'h00);
    rd(`MWD_REG_CTL, 8'h1e);
    rd(`MWD_REG_TOUT, 8'h02);
    kick = 1'b1;
    idle(30);
    f = pg_falls;
    repeat (16)
    begin
      idle(150);
      kick = ~kick;
    end
    check(8'(pg_falls - f), 8'h00);
    wr(`MWD_REG_TOUT, 8'h08);
    wr(`MWD_REG_CTL, 8'h01);
    wr(`MWD_REG_ALARM, `MWD_KEY_SVC);
    f = pg_falls;
    repeat (4)
    begin
      wr(`MWD_REG_CTL, 8'h01);
      wr(`MWD_REG_ALARM, `MWD_KEY_SVC);
    end
    check(8'(pg_falls - f), 8'h00);
    wr(`MWD_REG_CTL, 8'h01);
    wr(`MWD_REG_ALARM, 8'h55);
    wr(`MWD_REG_ALARM, `MWD_KEY_SVC);
    wait_pg(1000);
    wr(`MWD_REG_CTL, 8'h01);
    wait_pg(2000);
    rd(`MWD_REG_CTL, 8'h1e);
    do_reset(2'b01);
    wr(`MWD_REG_TOUT, 8'h01);
    wait_pg(1000);
    idle(50);
    rd(`MWD_REG_TOUT, `MWD_TOUT_RST);
    rd(`MWD_REG_HIST, 8'h01);
    do_reset(2'b00);
    wr(`MWD_REG_TOUT, 8'h01);
    wr(`MWD_REG_CTL, 8'h1e);
    wr(`MWD_REG_ALARM, `MWD_KEY_EN);
    f = pg_falls;
    idle(600);
    check(8'(pg_falls - f), 8'h00);
    rd(`MWD_REG_HIST, 8'h00);
    e = 8'h00;
    repeat (3)
    begin
      wr(`MWD_REG_DEV, 8'h00);
      rd(`MWD_REG_STAT, e);
      rng   = xs(rng);
      alarm = (rng[7:0] & 8'hfe) | 8'h08;
      m     = rng[15:8] | 8'h08;
      wr(`MWD_REG_MASK, m);
      // Let the off time of the status read run out before enabling
      idle(400);
      check({7'h00, int_n}, 8'h01);
      wr(`MWD_REG_DEV, 8'h20);
      check({7'h00, int_n}, 8'h00);
      e = exp_stat(alarm, m);
      rd(`MWD_REG_STAT, e);
      check({7'h00, int_n}, 8'h01);
      idle(1400);
      check({7'h00, int_n}, 8'h00);
    end
    close_out();
  end
endmodule
`default_nettype wire
